// ### cft_core.sv
// can acceptance filter, bit timing, time stamp, single shot, errors and irq lines

`include "cft_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module cft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two so the pointers wrap by themselves
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_reg + AW'(push);
      rd_reg <= rd_reg + AW'(pop);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cft_fifo

////////////////////////////////////////////////////////////////////////////////
module cft_core #(
  parameter int PRESC_W = 10,
  parameter int DEPTH = `CFT_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic ttc_en,
  input wire logic retransmit_disable,
  input wire logic auto_busoff_recover,
  input wire logic init_req,
  // bit timing
  input wire logic [PRESC_W-1:0] baud_prescaler,
  input wire logic [3:0] segment_one_field,
  input wire logic [2:0] segment_two_field,
  input wire logic [1:0] jump_width_field,
  // can pins
  input wire logic can_rx,
  output logic can_tx,
  // bit stream to and from the protocol engine
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic sof_bit,
  output logic sample_point,
  output logic rx_sample,
  output logic [`CFT_TS_W-1:0] time_stamp,
  // filter banks
  input wire logic [`CFT_BANKS-1:0] bank_fifo_sel,
  input wire logic [`CFT_BANKS-1:0] bank_scale32,
  input wire logic [`CFT_BANKS-1:0] bank_list_mode,
  input wire logic [`CFT_BANKS-1:0] bank_active,
  input wire cft_pkg::cft_word_t bank_data0 [`CFT_BANKS],
  input wire cft_pkg::cft_word_t bank_data1 [`CFT_BANKS],
  // received frames in
  input wire logic rx_frm_valid,
  output logic rx_frm_ready,
  input wire logic [28:0] rx_frm_id,
  input wire logic rx_frm_ide,
  input wire logic rx_frm_rtr,
  input wire logic [3:0] rx_frm_dlc,
  input wire logic [63:0] rx_frm_data,
  // accepted frames out
  output logic acc_valid,
  input wire logic acc_ready,
  output logic acc_fifo,
  output cft_pkg::cft_idx_t filter_match_index,
  output cft_pkg::cft_stamp_t acc_stamp,
  output logic [28:0] acc_id,
  output logic acc_ide,
  output logic acc_rtr,
  output logic [3:0] acc_dlc,
  output logic [63:0] acc_data,
  // transmit attempt results
  input wire logic tx_done,
  input wire logic [1:0] tx_mbox,
  input wire logic tx_ok,
  input wire logic tx_arb,
  input wire logic tx_err,
  input wire logic [2:0] mbox_start,
  input wire logic [2:0] mbox_clr,
  output logic tx_retry,
  output logic [2:0] mailbox_tx_finished,
  output logic [2:0] mailbox_tx_ok,
  output logic [2:0] mailbox_arb_lost,
  output logic [2:0] mailbox_tx_error,
  // error counting
  input wire logic tec_up8,
  input wire logic tec_dn1,
  input wire logic rec_up1,
  input wire logic rec_up8,
  input wire logic rec_dn1,
  input wire logic [2:0] last_error_code,
  output logic [8:0] tx_error_count,
  output logic [7:0] rx_error_count,
  output logic bus_off_flag,
  // interrupt sources and enables
  input wire logic tx_empty_irq_en,
  input wire logic [1:0] fifo0_frame_count,
  input wire logic fifo0_full_flag,
  input wire logic fifo0_overrun_flag,
  input wire logic fifo0_not_empty_irq_en,
  input wire logic fifo0_full_irq_en,
  input wire logic fifo0_overrun_irq_en,
  input wire logic [1:0] fifo1_frame_count,
  input wire logic fifo1_full_flag,
  input wire logic fifo1_overrun_flag,
  input wire logic fifo1_not_empty_irq_en,
  input wire logic fifo1_full_irq_en,
  input wire logic fifo1_overrun_irq_en,
  input wire logic busoff_irq_en,
  input wire logic passive_irq_en,
  input wire logic warn_irq_en,
  input wire logic code_irq_en,
  input wire logic error_irq_en,
  input wire logic wakeup_irq_en,
  input wire logic sleep_entry_irq_en,
  input wire logic error_flag_clr,
  input wire logic wakeup_evt,
  input wire logic wakeup_flag_clr,
  input wire logic sleep_evt,
  input wire logic sleep_state,
  input wire logic sleep_flag_clr,
  output logic error_irq_flag,
  output logic wakeup_irq_flag,
  output logic sleep_entry_flag,
  // interrupt lines
  output logic tx_irq,
  output logic fifo0_irq,
  output logic fifo1_irq,
  output logic err_irq
);
  import cft_pkg::*;

  localparam int WW = 1 + `CFT_IDX_W + `CFT_TS_W + 29 + 2 + 4 + 64;

  function automatic logic [4:0] cft_min5(input logic [4:0] a, input logic [4:0] b);
    cft_min5 = (a < b) ? a : b;
  endfunction : cft_min5

  function automatic logic cft_fmatch(input logic s32, input logic lst, input logic [1:0] k,
                                      input cft_word_t d0, input cft_word_t d1,
                                      input cft_word_t key);
    cft_word_t wd;
    logic [15:0] k16;
    wd = (lst ? k[1] : k[0]) ? d1 : d0;
    k16 = {key[31:21], key[1], key[2], key[20:18]};
    if (s32) begin
      cft_fmatch = lst ? (key == (k[0] ? d1 : d0)) : (((key ^ d0) & d1) == '0);
    end else if (lst) begin
      cft_fmatch = k16 == (k[0] ? wd[31:16] : wd[15:0]);
    end else begin
      cft_fmatch = ((k16 ^ wd[15:0]) & wd[31:16]) == '0;
    end
  endfunction : cft_fmatch

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and transmit drive
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_prev_reg;
  logic bus_off_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_s1_reg <= `CFT_RECESSIVE;
      rx_s2_reg <= `CFT_RECESSIVE;
      rx_prev_reg <= `CFT_RECESSIVE;
      can_tx <= `CFT_RECESSIVE;
    end else begin
      rx_s1_reg <= can_rx;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
      can_tx <= bus_off_reg ? `CFT_RECESSIVE : tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit timing
  cft_seg_t seg_reg;
  logic [PRESC_W-1:0] tq_cnt_reg;
  logic [4:0] seg_cnt_reg;
  logic [4:0] len1_reg;
  logic [4:0] len2_reg;
  logic edge_seen_reg;
  logic tq_tick;
  logic vedge;
  logic [4:0] sjwq;
  logic [4:0] len1_eff;
  logic [4:0] len2_eff;

  assign tq_tick = tq_cnt_reg == baud_prescaler;
  assign sjwq = {3'h0, jump_width_field} + 5'h01;
  // sending recessive hides our own edges, so they cannot move the bit
  assign vedge = rx_prev_reg == `CFT_DOMINANT && rx_s2_reg == `CFT_RECESSIVE &&
                 !edge_seen_reg && !(tx_active && can_tx == `CFT_RECESSIVE);
  assign len1_eff = (vedge && seg_reg == cft_seg_one) ?
                    len1_reg + cft_min5(seg_cnt_reg + 5'h01, sjwq) : len1_reg;
  assign len2_eff = (vedge && seg_reg == cft_seg_two) ?
                    ((len2_reg - sjwq > seg_cnt_reg && len2_reg > sjwq) ?
                     len2_reg - sjwq : seg_cnt_reg + 5'h01) : len2_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tq_cnt_reg <= '0;
    end else begin
      tq_cnt_reg <= tq_tick ? '0 : tq_cnt_reg + PRESC_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seg_reg <= cft_seg_sync;
      seg_cnt_reg <= '0;
      len1_reg <= 5'h01;
      len2_reg <= 5'h01;
      edge_seen_reg <= 1'b0;
      sample_point <= 1'b0;
      rx_sample <= `CFT_RECESSIVE;
    end else begin
      sample_point <= 1'b0;
      len1_reg <= len1_eff;
      len2_reg <= len2_eff;
      if (vedge) begin
        edge_seen_reg <= 1'b1;
      end
      if (tq_tick) begin
        unique case (seg_reg)
          cft_seg_sync: begin
            seg_reg <= cft_seg_one;
            seg_cnt_reg <= '0;
            len1_reg <= {1'b0, segment_one_field} + 5'h01;
            len2_reg <= {2'h0, segment_two_field} + 5'h01;
            edge_seen_reg <= 1'b0;
          end
          cft_seg_one: begin
            if (seg_cnt_reg + 5'h01 >= len1_eff) begin
              seg_reg <= cft_seg_two;
              seg_cnt_reg <= '0;
              sample_point <= 1'b1;
              rx_sample <= rx_s2_reg;
            end else begin
              seg_cnt_reg <= seg_cnt_reg + 5'h01;
            end
          end
          cft_seg_two: begin
            if (seg_cnt_reg + 5'h01 >= len2_eff) begin
              seg_reg <= cft_seg_sync;
              seg_cnt_reg <= '0;
            end else begin
              seg_cnt_reg <= seg_cnt_reg + 5'h01;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // time stamp
  cft_stamp_t ts_cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ts_cnt_reg <= '0;
      time_stamp <= '0;
    end else begin
      if (ttc_en && tq_tick && seg_reg == cft_seg_sync) begin
        ts_cnt_reg <= ts_cnt_reg + `CFT_TS_W'(1);
      end
      if (ttc_en && tq_tick && seg_reg == cft_seg_one && sof_bit &&
          seg_cnt_reg + 5'h01 >= len1_eff) begin
        time_stamp <= ts_cnt_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acceptance filter
  logic st_valid_reg;
  logic [28:0] st_id_reg;
  logic st_ide_reg;
  logic st_rtr_reg;
  logic [3:0] st_dlc_reg;
  logic [63:0] st_data_reg;
  cft_stamp_t st_stamp_reg;
  cft_word_t key;
  logic best_hit;
  logic best_fifo;
  logic [1:0] best_rank;
  cft_idx_t best_idx;
  logic take;
  logic push;
  logic f_ready;
  logic st_next;

  assign key = {st_id_reg, st_ide_reg, st_rtr_reg, 1'b0};

  always_comb begin
    cft_idx_t cnt0;
    cft_idx_t cnt1;
    cft_idx_t base;
    cft_idx_t n;
    cnt0 = '0;
    cnt1 = '0;
    base = '0;
    n = '0;
    best_hit = 1'b0;
    best_fifo = 1'b0;
    best_rank = '0;
    best_idx = '0;
    for (int b = 0; b < `CFT_BANKS; b++) begin
      n = bank_scale32[b] ? (bank_list_mode[b] ? `CFT_IDX_W'(2) : `CFT_IDX_W'(1)) :
                            (bank_list_mode[b] ? `CFT_IDX_W'(4) : `CFT_IDX_W'(2));
      base = bank_fifo_sel[b] ? cnt1 : cnt0;
      for (int k = 0; k < 4; k++) begin
        if (`CFT_IDX_W'(k) < n && bank_active[b] &&
            cft_fmatch(bank_scale32[b], bank_list_mode[b], 2'(k), bank_data0[b],
                       bank_data1[b], key) &&
            (!best_hit || {bank_scale32[b], bank_list_mode[b]} > best_rank)) begin
          best_hit = 1'b1;
          best_fifo = bank_fifo_sel[b];
          best_rank = {bank_scale32[b], bank_list_mode[b]};
          best_idx = base + `CFT_IDX_W'(k);
        end
      end
      if (bank_fifo_sel[b]) begin
        cnt1 = cnt1 + n;
      end else begin
        cnt0 = cnt0 + n;
      end
    end
  end

  // a frame that matches nothing leaves the stage without a push
  assign take = rx_frm_valid & rx_frm_ready;
  assign push = st_valid_reg & best_hit;
  assign st_next = take | (st_valid_reg & best_hit & ~f_ready);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_valid_reg <= 1'b0;
      rx_frm_ready <= 1'b0;
    end else begin
      st_valid_reg <= st_next;
      rx_frm_ready <= ~st_next & ~bus_off_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (take) begin
      st_id_reg <= rx_frm_id;
      st_ide_reg <= rx_frm_ide;
      st_rtr_reg <= rx_frm_rtr;
      st_dlc_reg <= rx_frm_dlc;
      st_data_reg <= rx_frm_data;
      st_stamp_reg <= time_stamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer and output register
  logic f_valid;
  logic f_pop;
  logic [WW-1:0] f_out;

  assign f_pop = ~acc_valid | acc_ready;

  cft_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data({best_fifo, best_idx, st_stamp_reg, st_id_reg, st_ide_reg, st_rtr_reg,
              st_dlc_reg, st_data_reg}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_valid <= 1'b0;
    end else if (f_pop) begin
      acc_valid <= f_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (f_pop && f_valid) begin
      {acc_fifo, filter_match_index, acc_stamp, acc_id, acc_ide, acc_rtr, acc_dlc,
       acc_data} <= f_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit outcome
  logic no_retry;
  logic [2:0] fin_set;
  logic [2:0] hit_mbox;

  assign no_retry = retransmit_disable | ttc_en;
  always_comb begin
    for (int m = 0; m < 3; m++) begin
      hit_mbox[m] = tx_done && tx_mbox == 2'(m);
      fin_set[m] = hit_mbox[m] && (tx_ok || no_retry);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_retry <= 1'b0;
      mailbox_tx_finished <= '0;
      mailbox_tx_ok <= '0;
      mailbox_arb_lost <= '0;
      mailbox_tx_error <= '0;
    end else begin
      tx_retry <= tx_done & ~tx_ok & ~no_retry;
      mailbox_tx_finished <= fin_set | (mailbox_tx_finished & ~mbox_clr);
      mailbox_tx_ok <= (fin_set & {3{tx_ok}}) |
                       (mailbox_tx_ok & ~mbox_clr & ~mbox_start);
      mailbox_arb_lost <= (fin_set & {3{tx_arb}}) |
                          (mailbox_arb_lost & ~mbox_clr & ~mbox_start);
      mailbox_tx_error <= (fin_set & {3{tx_err}}) |
                          (mailbox_tx_error & ~mbox_clr & ~mbox_start);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // error counters and bus off recovery
  logic rec_go_reg;
  logic init_seen_reg;
  logic [3:0] run_reg;
  logic [6:0] seq_reg;
  logic rec_done;
  logic passive;
  logic warn;

  assign rec_done = rec_go_reg && sample_point && rx_sample == `CFT_RECESSIVE &&
                    run_reg + 4'h1 == `CFT_RUN_LEN && seq_reg == `CFT_SEQ_LAST;
  assign passive = tx_error_count > {1'b0, `CFT_PASSIVE_LIMIT} ||
                   rx_error_count > `CFT_PASSIVE_LIMIT;
  assign warn = tx_error_count >= {1'b0, `CFT_WARN_LEVEL} || rx_error_count >= `CFT_WARN_LEVEL;
  assign bus_off_reg = bus_off_flag;

  always_ff @(posedge clk) begin
    if (!rst_b || rec_done) begin
      tx_error_count <= '0;
      rx_error_count <= '0;
      bus_off_flag <= 1'b0;
    end else if (!bus_off_flag) begin
      if (tec_up8) begin
        tx_error_count <= tx_error_count + `CFT_STEP_BIG;
      end else if (tec_dn1 && tx_error_count != '0) begin
        tx_error_count <= tx_error_count - `CFT_STEP_ONE;
      end
      if (rec_up8 && rx_error_count < 8'hf8) begin
        rx_error_count <= rx_error_count + 8'(`CFT_STEP_BIG);
      end else if (rec_up1 && rx_error_count != 8'hff) begin
        rx_error_count <= rx_error_count + 8'(`CFT_STEP_ONE);
      end else if (rec_dn1 && rx_error_count != '0) begin
        rx_error_count <= rx_error_count - 8'(`CFT_STEP_ONE);
      end
      bus_off_flag <= tx_error_count > `CFT_TEC_LIMIT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !bus_off_flag) begin
      rec_go_reg <= 1'b0;
      init_seen_reg <= 1'b0;
      run_reg <= '0;
      seq_reg <= '0;
    end else begin
      if (init_req) begin
        init_seen_reg <= 1'b1;
      end
      if (auto_busoff_recover || (init_seen_reg && !init_req)) begin
        rec_go_reg <= 1'b1;
      end
      if (rec_go_reg && sample_point) begin
        if (rx_sample != `CFT_RECESSIVE) begin
          run_reg <= '0;
        end else if (run_reg + 4'h1 == `CFT_RUN_LEN) begin
          run_reg <= '0;
          seq_reg <= seq_reg + 7'h01;
        end else begin
          run_reg <= run_reg + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags and interrupt lines
  logic err_set;

  assign err_set = (bus_off_flag & busoff_irq_en) | (passive & passive_irq_en) |
                   (warn & warn_irq_en) | (code_irq_en &&
                   last_error_code >= `CFT_LEC_MIN && last_error_code <= `CFT_LEC_MAX);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      error_irq_flag <= 1'b0;
      wakeup_irq_flag <= 1'b0;
      sleep_entry_flag <= 1'b0;
    end else begin
      error_irq_flag <= err_set | (error_irq_flag & ~error_flag_clr);
      wakeup_irq_flag <= wakeup_evt | (wakeup_irq_flag & ~wakeup_flag_clr);
      sleep_entry_flag <= sleep_evt | (sleep_entry_flag & ~sleep_flag_clr & sleep_state);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_irq <= 1'b0;
      fifo0_irq <= 1'b0;
      fifo1_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      tx_irq <= tx_empty_irq_en & (|mailbox_tx_finished);
      fifo0_irq <= (fifo0_frame_count != 2'h0 && fifo0_not_empty_irq_en) ||
                   (fifo0_full_flag && fifo0_full_irq_en) ||
                   (fifo0_overrun_flag && fifo0_overrun_irq_en);
      fifo1_irq <= (fifo1_frame_count != 2'h0 && fifo1_not_empty_irq_en) ||
                   (fifo1_full_flag && fifo1_full_irq_en) ||
                   (fifo1_overrun_flag && fifo1_overrun_irq_en);
      err_irq <= (error_irq_flag & error_irq_en) | (wakeup_irq_flag & wakeup_irq_en) |
                 (sleep_entry_flag & sleep_entry_irq_en);
    end
  end
endmodule : cft_core

// ### cft_consts.svh
// constants of the can filter, timing and error block
`ifndef CFT_CONSTS_SVH
`define CFT_CONSTS_SVH
`define CFT_BANKS 28
`define CFT_IDX_W 8
`define CFT_TS_W 16
`define CFT_FIFO_DEPTH 32
`define CFT_DOMINANT 1'b0
`define CFT_RECESSIVE 1'b1
`define CFT_TEC_LIMIT 9'h0ff
`define CFT_PASSIVE_LIMIT 8'h7f
`define CFT_WARN_LEVEL 8'h60
`define CFT_RUN_LEN 4'hb
`define CFT_SEQ_LAST 7'h7f
`define CFT_LEC_MIN 3'h1
`define CFT_LEC_MAX 3'h6
`define CFT_STEP_BIG 9'h008
`define CFT_STEP_ONE 9'h001
`endif

// ### cft_pkg.sv
// types shared by the can filter, timing and error block
`include "cft_consts.svh"
package cft_pkg;
  typedef enum logic [1:0] {
    cft_seg_sync = 2'b00,
    cft_seg_one = 2'b01,
    cft_seg_two = 2'b11
  } cft_seg_t;
  typedef logic [31:0] cft_word_t;
  typedef logic [`CFT_IDX_W-1:0] cft_idx_t;
  typedef logic [`CFT_TS_W-1:0] cft_stamp_t;
endpackage : cft_pkg

// ### cft_sva.sv
// concurrent checks on the can filter, timing and error ports
module cft_sva (
  // clock and reset
  input wire logic clk, rst_b,
  // transmit results
  input wire logic tx_done, retransmit_disable, ttc_en, tx_retry, tx_empty_irq_en, tx_irq,
  input wire logic [1:0] tx_mbox,
  input wire logic [2:0] mailbox_tx_finished,
  // errors and status
  input wire logic [8:0] tx_error_count,
  input wire logic bus_off_flag, can_tx, rx_frm_ready, busoff_irq_en, error_irq_flag,
  input wire logic error_irq_en, wakeup_irq_flag, wakeup_irq_en, sleep_entry_flag,
  input wire logic sleep_entry_irq_en, err_irq,
  // timing and frames
  input wire logic [15:0] time_stamp,
  input wire logic sample_point, acc_valid, acc_ready, acc_fifo
);
  wire tx_cause = tx_empty_irq_en && |mailbox_tx_finished;
  wire err_cause = error_irq_flag && error_irq_en || wakeup_irq_flag && wakeup_irq_en
    || sleep_entry_flag && sleep_entry_irq_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // past of rst_b keeps the first edge after reset out of the irq checks
  a_tx_irq_cause: assert property ($past(rst_b) |-> tx_irq == $past(tx_cause))
    else $error("tx irq");
  a_err_irq_cause: assert property ($past(rst_b) |-> err_irq == $past(err_cause))
    else $error("err irq");
  a_busoff_entry: assert property (tx_error_count[8] && !bus_off_flag |=> bus_off_flag)
    else $error("bus off late");
  a_busoff_quiet: assert property (bus_off_flag && $past(bus_off_flag) |->
    can_tx && !rx_frm_ready) else $error("bus off active");
  a_no_retry: assert property (tx_done && (retransmit_disable || ttc_en) |=> !tx_retry)
    else $error("retry");
  a_shot_done: assert property (tx_done && retransmit_disable |=>
    mailbox_tx_finished[$past(tx_mbox)]) else $error("not finished");
  a_err_flag_set: assert property (bus_off_flag && busoff_irq_en |-> ##[0:2] error_irq_flag)
    else $error("error flag");
  a_bit_min_gap: assert property (sample_point |=> (!sample_point) [*2])
    else $error("bit short");
  a_acc_hold: assert property (acc_valid && !acc_ready |=> acc_valid && $stable(acc_fifo))
    else $error("acc dropped");
  a_stamp_at_sp: assert property ($changed(time_stamp) |-> sample_point)
    else $error("stamp off sample point");
  c_single_shot: cover property (tx_done && retransmit_disable);
  c_bus_off: cover property ($rose(bus_off_flag));
  c_accept: cover property (acc_valid && acc_ready);
endmodule : cft_sva

bind cft_core cft_sva chk_u (.*);

// ### cft_node.sv
// behavioural model of the other nodes on the shared bus
module cft_node (
  // clock
  input wire logic clk,
  // bus
  input wire logic can_tx,
  input wire logic node_bit,
  output logic can_rx
);
  // wired and: any dominant bit wins, the bus idles recessive
  always_ff @(posedge clk) begin
    can_rx <= can_tx & node_bit;
  end
endmodule : cft_node

// ### cft_tb.sv
// self-checking bench of the can filter, timing and error block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cft_pkg::*;
  bit rst_b, ttc_en, retransmit_disable, auto_busoff_recover, init_req, tx_active, sof_bit;
  bit tx_bit = 1, node_bit = 1, rx_frm_valid, rx_frm_ide, rx_frm_rtr, acc_ready, tx_done;
  bit tx_ok, tx_arb, tx_err, tec_up8, tec_dn1, rec_up1, rec_up8, rec_dn1, tx_empty_irq_en;
  bit busoff_irq_en, passive_irq_en, warn_irq_en, code_irq_en, error_irq_en, wakeup_irq_en;
  bit sleep_entry_irq_en, error_flag_clr, wakeup_evt, wakeup_flag_clr, sleep_evt;
  bit sleep_state, sleep_flag_clr, fifo0_full_flag, fifo0_overrun_flag, fifo1_full_flag;
  bit fifo0_not_empty_irq_en, fifo0_full_irq_en, fifo0_overrun_irq_en, fifo1_overrun_flag;
  bit fifo1_not_empty_irq_en, fifo1_full_irq_en, fifo1_overrun_irq_en;
  bit [9:0] baud_prescaler;
  bit [3:0] segment_one_field, rx_frm_dlc;
  bit [2:0] segment_two_field, mbox_start, mbox_clr, last_error_code;
  bit [1:0] jump_width_field, tx_mbox, fifo0_frame_count, fifo1_frame_count;
  bit [27:0] bank_fifo_sel, bank_scale32, bank_list_mode, bank_active;
  bit [28:0] rx_frm_id;
  bit [63:0] rx_frm_data;
  cft_word_t bank_data0 [28], bank_data1 [28];
  logic clk, can_rx, can_tx, sample_point, rx_sample, rx_frm_ready, acc_valid, acc_fifo;
  logic acc_ide, acc_rtr, tx_retry, bus_off_flag, error_irq_flag, wakeup_irq_flag;
  logic sleep_entry_flag, tx_irq, fifo0_irq, fifo1_irq, err_irq;
  logic [15:0] time_stamp, ts;
  cft_stamp_t acc_stamp;
  cft_idx_t filter_match_index;
  logic [28:0] acc_id;
  logic [3:0] acc_dlc;
  logic [63:0] acc_data;
  logic [2:0] mailbox_tx_finished, mailbox_tx_ok, mailbox_arb_lost, mailbox_tx_error;
  logic [8:0] tx_error_count;
  logic [7:0] rx_error_count;
  int n_fail, samples_checked, cnt;
  // fifo0 then fifo1 {count, full, overrun, three enables}, then both irqs
  logic [15:0] rows [5] = '{16'h4882, 16'h2849, 16'h122a, 16'hf1fd, 16'h361e};
  cft_core dut_u (.*);
  cft_node node_u (.*);
  ////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic shot(logic [1:0] m, bit rd, bit tt, logic r);
    {tx_mbox, retransmit_disable, ttc_en, tx_done} = {m, rd, tt, 1'h1};
    step(1);
    tx_done = 0;
    chk("retry", r, tx_retry);
    step(1);
  endtask : shot
  task automatic frame(logic [28:0] id, logic fifo, logic [7:0] idx);
    rx_frm_id = id;
    rx_frm_valid = 1;
    while (rx_frm_ready !== 1'b1) step(1);
    step(1);
    rx_frm_valid = 0;
    for (cnt = 0; cnt < 20 && acc_valid !== 1'b1; cnt++) step(1);
    chk("acc id", id[15:0], acc_id[15:0]);
    chk("acc fifo", fifo, acc_fifo);
    chk("index", idx, filter_match_index);
    acc_ready = 1;
    step(1);
    acc_ready = 0;
  endtask : frame
  ////////////////////////////////////////
  initial begin
    bank_data0 = '{default: '0};
    bank_data1 = '{default: '0};
    step(16);
    chk("reset tx", 1'h1, can_tx);
    rst_b = 1;
    step(2);
    foreach (rows[i]) begin
      {fifo0_frame_count, fifo0_full_flag, fifo0_overrun_flag, fifo0_not_empty_irq_en,
        fifo0_full_irq_en, fifo0_overrun_irq_en, fifo1_frame_count, fifo1_full_flag,
        fifo1_overrun_flag, fifo1_not_empty_irq_en, fifo1_full_irq_en,
        fifo1_overrun_irq_en} = rows[i][15:2];
      step(2);
      chk("fifo irqs", rows[i][1:0], {fifo0_irq, fifo1_irq});
    end
    $display("irq table done");
    {tx_empty_irq_en, tx_arb} = 2'h3;
    shot(2'h1, 1'h1, 1'h0, 1'h0);
    chk("finished", 3'h2, mailbox_tx_finished);
    chk("arb lost", 3'h2, mailbox_arb_lost);
    step(1);
    chk("tx irq", 1'h1, tx_irq);
    {tx_arb, tx_err} = 2'h1;
    shot(2'h2, 1'h0, 1'h1, 1'h0);
    chk("tx error", 3'h4, mailbox_tx_error);
    shot(2'h0, 1'h0, 1'h0, 1'h1);
    mbox_clr = 3'h7;
    step(1);
    mbox_clr = 0;
    step(1);
    chk("tx irq off", 1'h0, tx_irq);
    $display("single shot done");
    {baud_prescaler, segment_one_field, segment_two_field, ttc_en, sof_bit} =
      {10'h1, 4'h2, 3'h1, 2'h3};
    repeat (3) begin
      cnt = 0;
      do begin
        step(1);
        cnt++;
      end while (sample_point !== 1'b1 && cnt < 99);
    end
    chk("bit clocks", 16'hc, 16'(cnt));
    ts = time_stamp;
    step(12);
    chk("stamp", ts + 16'h1, time_stamp);
    {baud_prescaler, segment_one_field, segment_two_field, ttc_en, sof_bit} = '0;
    $display("timing done");
    {bank_active, bank_fifo_sel, bank_scale32, bank_list_mode} = {28'h3, 28'h2, 28'h3, 28'h2};
    bank_data1[1] = 32'h0000_091c;
    rx_frm_ide = 1;
    frame(29'h123, 1'h1, 8'h1);
    frame(29'h124, 1'h0, 8'h0);
    $display("filter done");
    {busoff_irq_en, error_irq_en, tx_bit, tec_up8} = 4'hd;
    step(32);
    tec_up8 = 0;
    step(4);
    chk("tec", 16'h100, tx_error_count);
    chk("bus off", 1'h1, bus_off_flag);
    chk("tx idle", 1'h1, can_tx);
    chk("err irq", 1'h1, err_irq);
    step(300);
    chk("no recovery", 1'h1, bus_off_flag);
    auto_busoff_recover = 1;
    for (cnt = 0; cnt < 9000 && bus_off_flag === 1'b1; cnt++) step(1);
    chk("recovered", 1'h0, bus_off_flag);
    chk("long wait", 1'h1, cnt > 4000);
    {auto_busoff_recover, init_req, tec_up8} = 3'h3;
    step(36);
    {init_req, tec_up8} = 2'h0;
    for (cnt = 0; cnt < 9000 && bus_off_flag === 1'b1; cnt++) step(1);
    chk("sw recovery", 1'h0, bus_off_flag);
    chk("sw wait", 1'h1, cnt > 4000);
    $display("bus off done");
    results();
  end
endmodule : tb
